// file: rtl/pcr_core_if.sv
// Interface joining the register bank to its pause and LED helpers
`timescale 1ns/10ps
interface pcr_core_if;
  logic [1:0] adv_pause;
  logic [1:0] lp_pause;
  logic       full_duplex;
  logic       pause_rx;
  logic       pause_tx;
  logic       led_bypass;
  logic       led_mode;
  logic       link;
  logic       activity;
  logic       led;
  modport bank  (output adv_pause, output lp_pause, output full_duplex,
                 output led_bypass, output led_mode, output link,
                 output activity, input pause_rx, input pause_tx,
                 input led);
  modport pause (input adv_pause, input lp_pause, input full_duplex,
                 output pause_rx, output pause_tx);
  modport led_p (input led_bypass, input led_mode, input link,
                 input activity, output led);
endinterface // pcr_core_if

// file: rtl/pcr_led.sv
// Link LED driver with activity stretching
`timescale 1ns/10ps
module pcr_led #(
  parameter int STRETCH = pcr_pkg::STRETCH_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  pcr_core_if.led_p cif
);
  logic [pcr_pkg::STRETCH_W-1:0] cnt_r;
  logic                          act;

  // Stretching keeps short bursts visible to the eye
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (cif.activity) begin
      cnt_r <= pcr_pkg::STRETCH_W'(STRETCH);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign act = cif.led_bypass ? cif.activity : (cnt_r != '0);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cif.led <= 1'b0;
    end else if (cif.led_mode) begin
      cif.led <= cif.link;
    end else begin
      cif.led <= cif.link & ~act;
    end
  end
endmodule // pcr_led

// file: rtl/pcr_pause.sv
// Pause resolution from local and partner advertisement
`timescale 1ns/10ps
module pcr_pause (
  input  wire logic mclk,
  input  wire logic rst_n,
  pcr_core_if.pause cif
);
  logic lp_, la_, pp_, pa_;
  assign lp_ = cif.adv_pause[pcr_pkg::ADV_PAUSE];
  assign la_ = cif.adv_pause[pcr_pkg::ADV_ASYM];
  assign pp_ = cif.lp_pause[pcr_pkg::ADV_PAUSE];
  assign pa_ = cif.lp_pause[pcr_pkg::ADV_ASYM];

  // Half duplex keeps both results low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cif.pause_rx <= 1'b0;
      cif.pause_tx <= 1'b0;
    end else begin
      cif.pause_tx <= cif.full_duplex &
                      ((lp_ & pp_) | (~lp_ & la_ & pp_ & pa_));
      cif.pause_rx <= cif.full_duplex &
                      ((lp_ & pp_) | (lp_ & la_ & ~pp_ & pa_));
    end
  end
endmodule // pcr_pause

// file: rtl/pcr_pkg.sv
// Constants for the PHY control and 10Base-Te register bank
package pcr_pkg;
  // ----------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_PHY_CONTROL   = 8'h19;
  localparam logic [7:0]  IDX_TENBASE       = 8'h1a;
  localparam logic [9:0]  ADDR_PHY_CONTROL  = {IDX_PHY_CONTROL, 2'b00};
  localparam logic [9:0]  ADDR_TENBASE      = {IDX_TENBASE, 2'b00};
  // ----------------------------------------------------------------
  // Field positions of the control register
  // ----------------------------------------------------------------
  localparam int          B_AUTO_MDIX       = 15;
  localparam int          B_FORCE_MDIX      = 14;
  localparam int          B_PAUSE_RX        = 13;
  localparam int          B_PAUSE_TX        = 12;
  localparam int          B_MII_LINK        = 11;
  localparam int          B_LED_BYPASS      = 7;
  localparam int          B_LED_MODE        = 5;
  localparam int          B_ADDR_LO         = 0;
  localparam int          ADDR_W            = 5;
  // ----------------------------------------------------------------
  // Field positions of the 10Base-Te register
  // ----------------------------------------------------------------
  localparam int          B_LOW_THRESH      = 13;
  localparam int          B_SQUELCH_LO      = 9;
  localparam int          SQUELCH_W         = 4;
  localparam int          B_NLP_DIS         = 7;
  localparam int          B_POLARITY        = 4;
  localparam int          B_JABBER_DIS      = 0;
  // ----------------------------------------------------------------
  // Reset values and advertisement bits
  // ----------------------------------------------------------------
  localparam logic [3:0]  SQUELCH_RST       = 4'h0;
  localparam int          ADV_PAUSE         = 0;
  localparam int          ADV_ASYM          = 1;
  // ----------------------------------------------------------------
  // LED stretch timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ            = 10_000_000;
  localparam int          STRETCH_MS        = 50;
  localparam int          STRETCH_CYC       = CLK_HZ / 1000 * STRETCH_MS;
  localparam int          STRETCH_W         = 20;
endpackage

// file: rtl/pcr_top.sv
// PHY control and 10Base-Te register bank on an AHB-Lite slave
`timescale 1ns/10ps
module pcr_top #(
  parameter int STRETCH = pcr_pkg::STRETCH_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Strap pins, sampled after reset release
  input  wire logic        strap_auto_mdix,
  input  wire logic        strap_led_mode,
  input  wire logic [4:0]  strap_phy_addr,
  // PHY core status, same clock
  input  wire logic        link_up,
  input  wire logic        link_100_up,
  input  wire logic        full_duplex,
  input  wire logic [1:0]  local_advertisement_reg_pause,
  input  wire logic [1:0]  partner_ability_reg_pause,
  input  wire logic        rx_activity,
  input  wire logic        polarity_inverted,
  // Controls to the PHY core
  output logic             auto_mdix_en,
  output logic             rx_on_td_pair,
  output logic             low_rx_threshold,
  output logic      [3:0]  squelch_code,
  output logic             nlp_tx_en,
  output logic             jabber_en,
  output logic      [4:0]  phy_address,
  output logic             phy_status_reg_polarity,
  output logic             link_led
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pcr_core_if cif ();

  logic        auto_mdix_r;
  logic        force_mdix_r;
  logic        led_bypass_r;
  logic        led_mode_r;
  logic [4:0]  phy_addr_r;
  logic        low_thresh_r;
  logic [3:0]  squelch_r;
  logic        nlp_en_r;
  logic        polarity_r;
  logic        jabber_en_r;
  logic        mii_link_r;

  logic [6:0]  strap_m_r;
  logic [6:0]  strap_s_r;
  logic        strap_done_r;

  // Data phase state of the one transfer in flight
  logic        dph_r;
  logic        dph_write_r;
  logic [9:0]  dph_addr_r;
  logic        hready_r;
  logic [31:0] hrdata_r;

  // Decode strobes and read views
  logic        addr_take;
  logic        wr_ctrl;
  logic        wr_tenb;
  logic        rd_tenb;
  logic [15:0] ctrl_view;
  logic [15:0] tenb_view;

  // Address decode shared by the read mux and the write strobes
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = (a == r);
  endfunction

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Straps are pins, so two flops come before the latch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_m_r <= '0;
      strap_s_r <= '0;
    end else begin
      strap_m_r <= {strap_auto_mdix, strap_led_mode, strap_phy_addr};
      strap_s_r <= strap_m_r;
    end
  end

  // Latched on the third edge after release, once the chain has settled
  logic [1:0] strap_wait_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait_r <= 2'b00;
    end else begin
      strap_wait_r <= {strap_wait_r[0], 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
    end else if (strap_wait_r[1]) begin
      strap_done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait state on every transfer
  // ----------------------------------------------------------------
  assign addr_take = hsel & htrans[1] & hready;

  // Only the low ten address bits decode; the rest are ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dph_r       <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r  <= '0;
    end else if (addr_take) begin
      dph_r       <= 1'b1;
      dph_write_r <= hwrite;
      dph_addr_r  <= haddr[9:0];
    end else begin
      dph_r       <= 1'b0;
    end
  end

  // Low in the cycle after the address phase, so data comes from a flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hready_r <= 1'b1;
    end else begin
      hready_r <= ~addr_take;
    end
  end

  assign wr_ctrl = dph_r & dph_write_r &
                   hit(dph_addr_r, pcr_pkg::ADDR_PHY_CONTROL);
  assign wr_tenb = dph_r & dph_write_r &
                   hit(dph_addr_r, pcr_pkg::ADDR_TENBASE);
  assign rd_tenb = dph_r & ~dph_write_r &
                   hit(dph_addr_r, pcr_pkg::ADDR_TENBASE);

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_view = '0;
    ctrl_view[pcr_pkg::B_AUTO_MDIX]  = auto_mdix_r;
    ctrl_view[pcr_pkg::B_FORCE_MDIX] = force_mdix_r;
    ctrl_view[pcr_pkg::B_PAUSE_RX]   = cif.pause_rx;
    ctrl_view[pcr_pkg::B_PAUSE_TX]   = cif.pause_tx;
    ctrl_view[pcr_pkg::B_MII_LINK]   = mii_link_r;
    ctrl_view[pcr_pkg::B_LED_BYPASS] = led_bypass_r;
    ctrl_view[pcr_pkg::B_LED_MODE]   = led_mode_r;
    ctrl_view[pcr_pkg::B_ADDR_LO +: pcr_pkg::ADDR_W] = phy_addr_r;
  end

  always_comb begin
    tenb_view = '0;
    tenb_view[pcr_pkg::B_LOW_THRESH] = low_thresh_r;
    tenb_view[pcr_pkg::B_SQUELCH_LO +: pcr_pkg::SQUELCH_W] = squelch_r;
    tenb_view[pcr_pkg::B_NLP_DIS]    = ~nlp_en_r;
    tenb_view[pcr_pkg::B_POLARITY]   = polarity_r;
    tenb_view[pcr_pkg::B_JABBER_DIS] = ~jabber_en_r;
  end

  // Unmapped addresses read zero and still answer OKAY
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= '0;
    end else if (dph_r && !dph_write_r) begin
      if (hit(dph_addr_r, pcr_pkg::ADDR_PHY_CONTROL)) begin
        hrdata_r <= {16'h0000, ctrl_view};
      end else if (hit(dph_addr_r, pcr_pkg::ADDR_TENBASE)) begin
        hrdata_r <= {16'h0000, tenb_view};
      end else begin
        hrdata_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Straps land until the capture settles; software writes wait for that
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      auto_mdix_r <= 1'b0;
    end else if (!strap_done_r) begin
      auto_mdix_r <= strap_s_r[6];
    end else if (wr_ctrl) begin
      auto_mdix_r <= hwdata[pcr_pkg::B_AUTO_MDIX];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      force_mdix_r <= 1'b0;
    end else if (wr_ctrl && strap_done_r) begin
      force_mdix_r <= hwdata[pcr_pkg::B_FORCE_MDIX];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      led_bypass_r <= 1'b0;
    end else if (wr_ctrl && strap_done_r) begin
      led_bypass_r <= hwdata[pcr_pkg::B_LED_BYPASS];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      led_mode_r <= 1'b1;
    end else if (!strap_done_r) begin
      led_mode_r <= strap_s_r[5];
    end else if (wr_ctrl) begin
      led_mode_r <= hwdata[pcr_pkg::B_LED_MODE];
    end
  end

  // Read-only: software writes never reach the address
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phy_addr_r <= '0;
    end else if (!strap_done_r) begin
      phy_addr_r <= strap_s_r[4:0];
    end
  end

  // Shown one edge after the core reports it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mii_link_r <= 1'b0;
    end else begin
      mii_link_r <= link_100_up;
    end
  end

  // ----------------------------------------------------------------
  // 10Base-Te register
  // ----------------------------------------------------------------
  // Fields take effect on the edge that ends the wait state, one edge before the data phase completes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_thresh_r <= 1'b0;
    end else if (wr_tenb) begin
      low_thresh_r <= hwdata[pcr_pkg::B_LOW_THRESH];
    end
  end

  // Codes above 1000 are stored as written, with no clamping here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      squelch_r <= pcr_pkg::SQUELCH_RST;
    end else if (wr_tenb) begin
      squelch_r <= hwdata[pcr_pkg::B_SQUELCH_LO +:
                          pcr_pkg::SQUELCH_W];
    end
  end

  // Held as enables so that the pins come straight off the flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nlp_en_r <= 1'b1;
    end else if (wr_tenb) begin
      nlp_en_r <= ~hwdata[pcr_pkg::B_NLP_DIS];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      jabber_en_r <= 1'b1;
    end else if (wr_tenb) begin
      jabber_en_r <= ~hwdata[pcr_pkg::B_JABBER_DIS];
    end
  end

  // Sticky flag; a new detection in the clearing cycle wins over the read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      polarity_r <= 1'b0;
    end else if (polarity_inverted) begin
      polarity_r <= 1'b1;
    end else if (rd_tenb) begin
      polarity_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  assign cif.adv_pause   = local_advertisement_reg_pause;
  assign cif.lp_pause    = partner_ability_reg_pause;
  assign cif.full_duplex = full_duplex;
  assign cif.led_bypass  = led_bypass_r;
  assign cif.led_mode    = led_mode_r;
  assign cif.link        = link_up;
  assign cif.activity    = rx_activity;

  // Pause results arrive one edge after their inputs
  pcr_pause u_pause (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cif   (cif.pause)
  );

  pcr_led #(
    .STRETCH (STRETCH)
  ) u_led (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cif   (cif.led_p)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The polarity mirror shares the flop, so only one clear path exists
  assign phy_status_reg_polarity = polarity_r;
  assign auto_mdix_en      = auto_mdix_r;
  assign rx_on_td_pair     = force_mdix_r;
  assign low_rx_threshold  = low_thresh_r;
  assign squelch_code      = squelch_r;
  assign nlp_tx_en         = nlp_en_r;
  assign jabber_en         = jabber_en_r;
  assign phy_address       = phy_addr_r;
  assign link_led          = cif.led;
  assign hrdata            = hrdata_r;
  assign hreadyout         = hready_r;
  assign hresp             = 1'b0;

  // Bus inputs that carry no meaning here, folded so they are read
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:10]};
endmodule // pcr_top

// file: tb/pcr_assertions.sv
// Concurrent checks on the ports of the PHY control register bank
`timescale 1ns/10ps
module pcr_checker (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        auto_mdix_en,
  input wire logic        rx_on_td_pair,
  input wire logic        low_rx_threshold,
  input wire logic [3:0]  squelch_code,
  input wire logic        nlp_tx_en,
  input wire logic        jabber_en,
  input wire logic        polarity_inverted,
  input wire logic        phy_status_reg_polarity
);
  logic       take;
  logic       w_ctl_r;
  logic       w_ten_r;
  logic       r_ten_r;
  logic       ctl_c;
  logic       ten_c;
  logic       rd_c;
  assign take  = hsel & htrans[1] & hready;
  assign ctl_c = w_ctl_r & !hreadyout;
  assign ten_c = w_ten_r & !hreadyout;
  assign rd_c  = r_ten_r & !hreadyout;
  // Only one transfer in flight, so a flag per kind is enough
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      w_ctl_r <= 1'b0;
      w_ten_r <= 1'b0;
      r_ten_r <= 1'b0;
    end else begin
      w_ctl_r <= take & hwrite & (haddr[9:0] == pcr_pkg::ADDR_PHY_CONTROL);
      w_ten_r <= take & hwrite & (haddr[9:0] == pcr_pkg::ADDR_TENBASE);
      r_ten_r <= take & !hwrite & (haddr[9:0] == pcr_pkg::ADDR_TENBASE);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  ctl_write_a: assert property (ctl_c |=> ##1
    auto_mdix_en == $past(hwdata[15], 2) &&
    rx_on_td_pair == $past(hwdata[14], 2)) else $error("crossover mismatch");
  thresh_write_a: assert property (ten_c |=> ##1
    low_rx_threshold == $past(hwdata[13], 2)) else $error("threshold bad");
  squelch_write_a: assert property (ten_c |=> ##1
    squelch_code == $past(hwdata[12:9], 2)) else $error("squelch bad");
  nlp_write_a: assert property (ten_c |=> ##1
    nlp_tx_en == !$past(hwdata[7], 2)) else $error("link pulse bad");
  jabber_write_a: assert property (ten_c |=> ##1
    jabber_en == !$past(hwdata[0], 2)) else $error("jabber bad");
  pol_set_a: assert property (polarity_inverted |=>
    phy_status_reg_polarity) else $error("polarity not set");
  pol_clear_a: assert property (rd_c && !polarity_inverted |=>
    !phy_status_reg_polarity) else $error("polarity not cleared");
  pol_hold_a: assert property (phy_status_reg_polarity && !rd_c
    |=> phy_status_reg_polarity) else $error("polarity lost");
  pol_read_a: assert property (rd_c |=>
    hrdata[4] == $past(phy_status_reg_polarity)) else $error("polarity read");
  cover property (ctl_c);
  cover property (ten_c);
  cover property (rd_c && phy_status_reg_polarity);
  cover property (rd_c && polarity_inverted);
endmodule // pcr_checker
bind pcr_top pcr_checker chk_u (.mclk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .auto_mdix_en,
  .rx_on_td_pair, .low_rx_threshold, .squelch_code, .nlp_tx_en, .jabber_en,
  .polarity_inverted, .phy_status_reg_polarity);

// file: tb/phy_control_and_tenbase_regs_tb_top.sv
// Self-checking bench of the PHY control register bank
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module phy_control_and_tenbase_regs_tb_top;
  localparam int ST = 8;
  logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, link_led;
  logic [31:0] haddr, hwdata, hrdata, r, d, d2;
  logic [1:0]  htrans, lap, pap;
  logic [2:0]  hsize;
  logic [3:0]  squelch_code;
  logic [4:0]  strap_phy_addr, phy_address;
  logic        strap_auto_mdix, strap_led_mode, link_up, link_100_up;
  logic        full_duplex, rx_activity, polarity_inverted, auto_mdix_en;
  logic        rx_on_td_pair, low_rx_threshold, nlp_tx_en, jabber_en;
  logic        phy_status_reg_polarity;
  wire         hready;
  int          n_fail, comparisons, seed;
  assign hready = hreadyout;
  pcr_top #(.STRETCH(ST)) dut_u (.mclk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .strap_auto_mdix, .strap_led_mode, .strap_phy_addr, .link_up,
    .link_100_up, .full_duplex, .local_advertisement_reg_pause(lap),
    .partner_ability_reg_pause(pap), .rx_activity, .polarity_inverted,
    .auto_mdix_en, .rx_on_td_pair, .low_rx_threshold, .squelch_code,
    .nlp_tx_en, .jabber_en, .phy_address, .phy_status_reg_polarity,
    .link_led);
  always #50 mclk = ~mclk;
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for hready high at a rising edge
  task wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      report_and_stop;
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, dw, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= dw;
    wait_rdy;
    q = hrdata;
  endtask
  function logic [1:0] pause_of(input logic fd, input logic [1:0] a, p);
    pause_of[1] = fd & ((a[0] & p[0]) | (a == 2'b11 && p == 2'b10));
    pause_of[0] = fd & ((a[0] & p[0]) | (a == 2'b10 && p == 2'b11));
  endfunction
  function logic [31:0] exp_ctl(input logic [31:0] v);
    exp_ctl = {16'h0000, v[15:14], pause_of(full_duplex, lap, pap),
               link_100_up, 3'b000, v[7], 1'b0, v[5], strap_phy_addr};
  endfunction
  initial begin
    seed = 32'hfafd;
    n_fail = 0;
    comparisons = 0;
    {mclk, rst_n, hsel, hwrite, link_up, link_100_up, full_duplex} = 7'h00;
    {rx_activity, polarity_inverted, lap, pap} = 6'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    {strap_auto_mdix, strap_led_mode, strap_phy_addr} = 7'($random(seed));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    xfer(1'b0, pcr_pkg::ADDR_PHY_CONTROL, 32'h0, r);
    d = {16'h0000, strap_auto_mdix, 9'h000, strap_led_mode, strap_phy_addr};
    `CHK(r, d)
    `CHK(phy_address, strap_phy_addr)
    `CHK({nlp_tx_en, jabber_en}, 2'b11)
    xfer(1'b0, pcr_pkg::ADDR_TENBASE, 32'h0, r);
    `CHK(r, 32'h0000_0000)
    for (int i = 0; i < 32; i++) begin
      {full_duplex, lap, pap} <= i[4:0];
      link_100_up <= 1'($random(seed));
      d = (i < 2) ? {32{~i[0]}} : $random(seed);
      d2 = (i < 9) ? ($random(seed) & ~32'h1e00) | (i << 9) : $random(seed);
      xfer(1'b1, pcr_pkg::ADDR_PHY_CONTROL, d, r);
      xfer(1'b1, pcr_pkg::ADDR_TENBASE, d2, r);
      xfer(1'b0, pcr_pkg::ADDR_PHY_CONTROL, 32'h0, r);
      `CHK(r, exp_ctl(d))
      xfer(1'b0, pcr_pkg::ADDR_TENBASE, 32'h0, r);
      `CHK(r, d2 & 32'h0000_3e81)
      `CHK({auto_mdix_en, rx_on_td_pair}, d[15:14])
      `CHK({low_rx_threshold, squelch_code}, d2[13:9])
      `CHK({nlp_tx_en, jabber_en}, ~{d2[7], d2[0]})
    end
    xfer(1'b1, 32'h0000_006c, $random(seed), r);
    xfer(1'b0, 32'h0000_006c, 32'h0, r);
    `CHK(r, 32'h0000_0000)
    xfer(1'b0, 32'h0000_0060, 32'h0, r);
    `CHK(r, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    polarity_inverted <= 1'b1;
    @(posedge mclk);
    polarity_inverted <= 1'b0;
    @(posedge mclk);
    xfer(1'b0, pcr_pkg::ADDR_PHY_CONTROL, 32'h0, r);
    `CHK(phy_status_reg_polarity, 1'b1)
    xfer(1'b0, pcr_pkg::ADDR_TENBASE, 32'h0, r);
    `CHK(r, (d2 & 32'h0000_3e81) | 32'h0000_0010)
    `CHK(phy_status_reg_polarity, 1'b0)
    xfer(1'b0, pcr_pkg::ADDR_TENBASE, 32'h0, r);
    `CHK(r[4], 1'b0)
    // Detection during the clearing read: the set must win
    polarity_inverted <= 1'b1;
    xfer(1'b0, pcr_pkg::ADDR_TENBASE, 32'h0, r);
    polarity_inverted <= 1'b0;
    `CHK(r[4], 1'b1)
    `CHK(phy_status_reg_polarity, 1'b1)
    xfer(1'b0, pcr_pkg::ADDR_TENBASE, 32'h0, r);
    `CHK(phy_status_reg_polarity, 1'b0)
    link_up <= 1'b1;
    xfer(1'b1, pcr_pkg::ADDR_PHY_CONTROL, 32'h0000_0020, r);
    rx_activity <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(link_led, 1'b1)
    xfer(1'b1, pcr_pkg::ADDR_PHY_CONTROL, 32'h0000_0080, r);
    repeat (3) @(posedge mclk);
    `CHK(link_led, 1'b0)
    rx_activity <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(link_led, 1'b1)
    xfer(1'b1, pcr_pkg::ADDR_PHY_CONTROL, 32'h0, r);
    rx_activity <= 1'b1;
    @(posedge mclk);
    rx_activity <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(link_led, 1'b0)
    repeat (ST + 4) @(posedge mclk);
    `CHK(link_led, 1'b1)
    link_up <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(link_led, 1'b0)
    report_and_stop;
  end
endmodule // phy_control_and_tenbase_regs_tb_top
